/* File: dv/sts_master.sv */
// SMBus master model driving the thermometer clock and data pins
`timescale 1ns/10ps
`default_nettype none
module sts_master (
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // ----------------
    // Pin steps
    // ----------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Data moves only while clock is low; high phase under the timeout
    task automatic bit_io(input logic d, output logic q);
        scl <= 1'b0;
        w(14);
        sda_low <= !d;
        w(14);
        scl <= 1'b1;
        w(10);
        q = sda_line;
        w(3);
    endtask
    // Low phase outlasts the slave's ack release, up to about 240 ns
    task automatic start();
        scl <= 1'b0;
        w(10);
        sda_low <= 1'b0;
        w(20);
        scl <= 1'b1;
        w(10);
        sda_low <= 1'b1;
        w(10);
    endtask
    task automatic stop();
        scl <= 1'b0;
        w(10);
        sda_low <= 1'b1;
        w(20);
        scl <= 1'b1;
        w(10);
        sda_low <= 1'b0;
        w(20);
    endtask
    task automatic xbyte(input logic [7:0] d, input logic mack,
                         output logic [7:0] q, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], b);
            q[i] = b;
        end
        bit_io(mack, b);
        ack = !b;
    endtask
    // Low byte first; PEC byte is sent but not judged by the slave
    task automatic write_word(input logic [6:0] na, input logic [3:0] wa,
                              input logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic       a;
        start();
        xbyte({na, 1'b0}, 1'b1, q, ok);
        xbyte({4'h1, wa}, 1'b1, q, a);
        xbyte(d[7:0], 1'b1, q, a);
        xbyte(d[15:8], 1'b1, q, a);
        xbyte(8'h00, 1'b1, q, a);
        stop();
    endtask
    task automatic read_word(input logic [6:0] na, input logic [3:0] wa,
                             output logic [15:0] d, output logic [7:0] p,
                             output logic ok);
        logic [7:0] q;
        logic       a;
        start();
        xbyte({na, 1'b0}, 1'b1, q, ok);
        xbyte({4'h1, wa}, 1'b1, q, a);
        start();
        xbyte({na, 1'b1}, 1'b1, q, a);
        ok = ok & a;
        xbyte(8'hff, 1'b0, d[7:0], a);
        xbyte(8'hff, 1'b0, d[15:8], a);
        xbyte(8'hff, 1'b1, p, a);
        stop();
    endtask
    task automatic hold_low(input int n);
        scl <= 1'b0;
        w(n);
        scl <= 1'b1;
        w(20);
    endtask
    // Park the clock after the address ack; next byte acked only if no timeout
    task automatic stall(input logic [6:0] na, input logic lvl,
                         input int n, output logic ack);
        logic [7:0] q;
        start();
        xbyte({na, 1'b0}, 1'b1, q, ack);
        scl <= lvl;
        w(n);
        xbyte(8'h10, 1'b1, q, ack);
        stop();
    endtask
endmodule
`default_nettype wire

/* File: dv/sts_slave_chk.sv */
// Port checker for the thermometer serial slave
`timescale 1ns/10ps
`default_nettype none
module sts_slave_chk #(
    parameter int REQ_CYC  = 200,
    parameter int WAKE_CYC = 50
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        clk_link,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sleep_req,
    input wire logic [15:0] ambient_temp,
    input wire logic [15:0] object_temp,
    input wire logic        sda_oe,
    input wire logic        por_weak_oe,
    input wire logic        pwm_active,
    input wire logic        pwm_sel_ambient,
    input wire logic [14:0] pwm_floor,
    input wire logic [14:0] pwm_span,
    input wire logic [15:0] pwm_value,
    input wire logic        awake
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Present clock-low run length, saturating
    logic [15:0] low_cnt;
    always_ff @(posedge clk_sys) begin
        if (scl_in)
            low_cnt <= 16'h0000;
        else if (low_cnt != 16'hffff)
            low_cnt <= low_cnt + 16'h0001;
    end
    sequence s_steady;
        pwm_active && $stable(ambient_temp) && $stable(object_temp);
    endsequence
    sequence s_loaded;
        pwm_floor == sts_pkg::RST_FLOOR_ADDR[14:0] &&
            pwm_span == sts_pkg::RST_SPAN[14:0] && !pwm_active;
    endsequence
    a_por_pin: assert property (
        disable iff (1'b0) por_weak_oe == !rst_n)
        else $error("weak reset pin level wrong");
    a_defaults_load: assert property (
        $rose(rst_n) |-> ##[1:40] s_loaded)
        else $error("defaults not applied after reset");
    a_pwm_bus_quiet: assert property (
        pwm_active |-> !sda_oe)
        else $error("data pulled while in pwm mode");
    a_drive_clock_low: assert property (
        $rose(sda_oe) |-> !scl_in)
        else $error("data pulled while clock high");
    a_release_clock_low: assert property (
        $fell(sda_oe) && scl_in |-> $past(scl_in, 30))
        else $error("data released while clock high");
    a_pwm_exit_run: assert property (
        $fell(pwm_active) |-> low_cnt >= REQ_CYC - 8)
        else $error("pwm left without long clock low");
    a_wake_run: assert property (
        $rose(awake) |-> low_cnt >= WAKE_CYC - 8)
        else $error("woke without long clock low");
    a_pwm_value_src: assert property (
        s_steady [*6] |->
            pwm_value == (pwm_sel_ambient ? ambient_temp : object_temp))
        else $error("pwm value from wrong source");
endmodule
bind sts_slave sts_slave_chk #(.REQ_CYC(REQ_CYC), .WAKE_CYC(WAKE_CYC))
    u_chk (.clk_sys, .rst_n, .clk_link, .scl_in, .sda_in, .sleep_req,
    .ambient_temp, .object_temp, .sda_oe, .por_weak_oe, .pwm_active,
    .pwm_sel_ambient, .pwm_floor, .pwm_span, .pwm_value, .awake);
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the thermometer serial slave
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int REQ  = 200;
    localparam int WAKE = 50;
    logic        clk_sys      = 1'b0;
    logic        clk_link     = 1'b0;
    logic        rst_n        = 1'b0;
    logic        sleep_req    = 1'b0;
    logic [15:0] ambient_temp = 16'h0000;
    logic [15:0] object_temp  = 16'h0000;
    logic        sda_oe, por_weak_oe, pwm_active, pwm_sel_ambient, awake;
    logic [14:0] pwm_floor, pwm_span;
    logic [15:0] pwm_value;
    logic [15:0] mem [16];
    logic        m_scl, m_low, ok;
    logic [3:0]  ml [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hd, 4'he, 4'hf};
    logic [3:0]  wl [4] = '{4'h1, 4'h3, 4'he, 4'hf};
    wire logic   sda_line;
    int          fail_count   = 0;
    int          total_checks = 0;
    int          seed         = 53676;
    // Pull-up wins unless someone pulls low
    assign sda_line = !(m_low || sda_oe);
    always #5 clk_sys = ~clk_sys;
    // Link clock offset so its edges drift against the system clock
    initial begin
        #7;
        forever #24 clk_link = ~clk_link;
    end
    // Identifier values are arbitrary
    sts_slave #(.REQ_CYC(REQ), .WAKE_CYC(WAKE), .LOW_TO_CYC(150),
        .HIGH_TO_CYC(40), .ID_LOW(16'h0a5c), .ID_HIGH(16'h0c3a)) dut (
        .clk_sys, .rst_n, .clk_link, .scl_in(m_scl), .sda_in(sda_line),
        .sleep_req, .ambient_temp, .object_temp, .sda_oe, .por_weak_oe,
        .pwm_active, .pwm_sel_ambient, .pwm_floor, .pwm_span, .pwm_value,
        .awake);
    sts_master m (.clk_sys, .sda_line, .scl(m_scl), .sda_low(m_low));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                         input logic [7:0] b);
        logic [7:0] x;
        x = c ^ b;
        for (int i = 0; i < 8; i++)
            x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
        return x;
    endfunction
    task automatic rd(input logic [6:0] na, input logic [3:0] wa,
                      input logic exp_ack);
        logic [15:0] d;
        logic [7:0]  p;
        logic [7:0]  e;
        m.read_word(na, wa, d, p, ok);
        chk(ok, exp_ack);
        // PEC restarts at every start, so it covers the read address and the two data bytes only
        e = crc8(8'h00, {na, 1'b1});
        if (exp_ack) begin
            chk(d, mem[wa]);
            chk(p, crc8(crc8(e, mem[wa][7:0]), mem[wa][15:8]));
        end
    endtask
    task automatic wr(input logic [6:0] na, input logic [3:0] wa,
                      input logic [15:0] d, input logic exp_ack);
        m.write_word(na, wa, d, ok);
        chk(ok, exp_ack);
        if (exp_ack && wa < 4'he)
            mem[wa] = d;
    endtask
    task automatic wait_pwm(input logic want);
        for (int i = 0; i < 400; i++) begin
            if (pwm_active === want)
                return;
            @(posedge clk_sys);
        end
        fail_count++;
        finish_test();
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        finish_test();
    end
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        for (int i = 0; i < 16; i++)
            mem[i] = 16'h0000;
        mem[0] = 16'h355b;
        mem[1] = 16'h09c4;
        mem[2] = 16'h0001;
        mem[3] = 16'h4000;
        mem[14] = 16'h0a5c;
        mem[15] = 16'h0c3a;
        // Longer than 16 cycles so four link edges land in reset
        repeat (20) @(posedge clk_sys);
        chk(por_weak_oe, 1'b1);
        rst_n <= 1'b1;
        repeat (60) @(posedge clk_sys);
        chk(por_weak_oe, 1'b0);
        chk(pwm_floor, 15'h355b);
        chk(pwm_span, 15'h09c4);
        chk(pwm_active, 1'b0);
        foreach (ml[i])
            rd(7'h5b, ml[i], 1'b1);
        rd(7'h00, 4'h3, 1'b1);
        rd(7'h22, 4'h1, 1'b0);
        foreach (wl[i]) begin
            wr(7'h5b, wl[i], 16'($random(seed)), 1'b1);
            rd(7'h5b, wl[i], 1'b1);
        end
        chk(pwm_span, mem[1][14:0]);
        wr(7'h5b, 4'h0, 16'h1233, 1'b1);
        rd(7'h5b, 4'h0, 1'b0);
        rd(7'h33, 4'h0, 1'b1);
        chk(pwm_floor, 15'h1233);
        wr(7'h33, 4'h0, 16'hc47f, 1'b1);
        rd(7'h7f, 4'h0, 1'b1);
        chk(pwm_floor, 15'h447f);
        m.stall(7'h7f, 1'b1, 300, ok);
        chk(ok, 1'b0);
        m.stall(7'h7f, 1'b0, 900, ok);
        chk(ok, 1'b0);
        rd(7'h7f, 4'h1, 1'b1);
        sleep_req <= 1'b1;
        repeat (20) @(posedge clk_sys);
        sleep_req <= 1'b0;
        chk(awake, 1'b0);
        m.hold_low(WAKE / 2);
        chk(awake, 1'b0);
        m.hold_low(WAKE * 2);
        chk(awake, 1'b1);
        ambient_temp <= 16'($random(seed));
        object_temp <= 16'($random(seed));
        wr(7'h7f, 4'h2, 16'h0005, 1'b1);
        chk(pwm_sel_ambient, 1'b1);
        chk(pwm_value, ambient_temp);
        wr(7'h7f, 4'h2, 16'h0000, 1'b1);
        wait_pwm(1'b1);
        repeat (10) @(posedge clk_sys);
        chk(pwm_sel_ambient, 1'b0);
        chk(pwm_value, object_temp);
        rd(7'h7f, 4'h2, 1'b0);
        m.hold_low(REQ / 2);
        chk(pwm_active, 1'b1);
        m.hold_low(REQ * 2);
        wait_pwm(1'b0);
        rd(7'h7f, 4'h2, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire

/* File: pkg/sts_pkg.sv */
// Package: constants, types and map of the thermometer serial slave
package sts_pkg;
    // EEPROM word offsets
    localparam logic [3:0] OFF_FLOOR_ADDR = 4'h0;
    localparam logic [3:0] OFF_SPAN       = 4'h1;
    localparam logic [3:0] OFF_CONFIG     = 4'h2;
    localparam logic [3:0] OFF_EMISS      = 4'h3;
    localparam logic [3:0] OFF_CAL_FIRST  = 4'h4;
    localparam logic [3:0] OFF_CAL_LAST   = 4'hd;
    localparam logic [3:0] OFF_ID_LOW     = 4'he;
    localparam logic [3:0] OFF_ID_HIGH    = 4'hf;
    // Reset values
    localparam logic [15:0] RST_FLOOR_ADDR = 16'h355b;
    localparam logic [15:0] RST_SPAN       = 16'h09c4;
    localparam logic [15:0] RST_CONFIG     = 16'h0001;
    localparam logic [15:0] RST_EMISS      = 16'h4000;
    localparam logic [15:0] RST_CAL        = 16'h0000;
    // Field layout
    localparam int         ADDR_MSB    = 6;
    localparam int         TEMP_MSB    = 14;
    localparam int         CFG_SEL_BIT = 0;
    localparam logic [6:0] GEN_CALL    = 7'h00;
    localparam logic [6:0] ADDR_MIN    = 7'h01;
    localparam int         WORD_BITS   = 16;
    localparam int         PEC_BITS    = 8;
    localparam logic [7:0] CRC_POLY    = 8'h07;
    // Times in their printed units and the system rate
    localparam int CLK_MHZ      = 100;
    localparam int T_REQ_MS     = 39;
    localparam int T_WAKE_MS    = 8;
    localparam int T_LOW_TO_MS  = 21;
    localparam int T_HIGH_TO_US = 52;
    localparam int REQ_CYC      = T_REQ_MS * 1000 * CLK_MHZ;
    localparam int WAKE_CYC     = T_WAKE_MS * 1000 * CLK_MHZ;
    localparam int LOW_TO_CYC   = T_LOW_TO_MS * 1000 * CLK_MHZ;
    localparam int HIGH_TO_CYC  = T_HIGH_TO_US * CLK_MHZ;
    // Bus engine states
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_ADDR  = 7'b0000010,
        ST_AACK  = 7'b0000100,
        ST_WRB   = 7'b0001000,
        ST_WACK  = 7'b0010000,
        ST_RDB   = 7'b0100000,
        ST_RACK  = 7'b1000000
    } sts_state_e;
    // Pin sample carrier
    typedef struct packed {
        logic scl;
        logic sda;
    } sts_pins_s;
    // Word write request crossing to the system domain
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] data;
    } sts_wr_s;
endpackage

/* File: rtl/sts_slave.sv */
// Serial slave and configuration word store of the infrared thermometer
// Notes on behaviour
// R1: Slave only, never starts a transfer
// R2: Own address is word 0 bits 6..0
// R3: Address zero always answers too
// R4: Addresses 01..7f usable, default 5b
// R5: Word map floor span config emiss cal id
// R6: All words readable, identifier words not writable
// R7: Master keeps calibration words unchanged
// R8: Floor is 15-bit field, default 355b
// R9: Span is 15-bit field, default 09c4
// R10: Config word applied after reset
// R11: Data pin shows reset weakly during reset
// R12: Selected PWM carries object or ambient
// R13: Results via serial or PWM, never both
// R14: Filter output results stored in RAM
// R15: IIR smoothing keeps RAM refresh rate
// R16: Temperatures carry 0.02 degree steps
// R17: All timeouts from internal oscillator; the clock-high and clock-low bus timeouts count clk_link cycles
// R18: Long clock low leaves PWM mode
// R19: Config bit 0 selects serial or PWM
// R20: Reads return 16 bits plus PEC
// R21: Emissivity defaults to 4000
// R22: Clock timeouts drop partial transfers
// R23: Clock low wakeup ends power saving
`timescale 1ns/10ps
`default_nettype none
module sts_slave #(
    parameter int REQ_CYC     = sts_pkg::REQ_CYC,
    parameter int WAKE_CYC    = sts_pkg::WAKE_CYC,
    parameter int LOW_TO_CYC  = sts_pkg::LOW_TO_CYC,
    parameter int HIGH_TO_CYC = sts_pkg::HIGH_TO_CYC,
    parameter logic [15:0] ID_LOW  = 16'h1234,
    parameter logic [15:0] ID_HIGH = 16'h5678
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_link,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        sleep_req,
    input  wire logic [15:0] ambient_temp,
    input  wire logic [15:0] object_temp,
    output logic             sda_oe,
    output logic             por_weak_oe,
    output logic             pwm_active,
    output logic             pwm_sel_ambient,
    output logic [14:0]      pwm_floor,
    output logic [14:0]      pwm_span,
    output logic [15:0]      pwm_value,
    output logic             awake
);
    // ------------------------------------------------------------
    // Pin synchronisers, three stages, change on stages two and three
    // ------------------------------------------------------------
    sts_pkg::sts_pins_s s1_reg, s2_reg, s3_reg, pin_reg, pin_prev_reg;
    // Link clock samples the pins; first stage feeds only stage two
    always_ff @(posedge clk_link) begin
        if (!rst_n) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
        end else begin
            s1_reg <= '{scl: scl_in, sda: sda_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // Accept a level only when stages two and three agree
    always_ff @(posedge clk_link) begin
        if (!rst_n) begin
            pin_reg      <= '1;
            pin_prev_reg <= '1;
        end else begin
            if (s2_reg.scl == s3_reg.scl) pin_reg.scl <= s3_reg.scl;
            if (s2_reg.sda == s3_reg.sda) pin_reg.sda <= s3_reg.sda;
            pin_prev_reg <= pin_reg;
        end
    end
    wire logic scl_rise = pin_reg.scl & ~pin_prev_reg.scl;
    wire logic scl_fall = ~pin_reg.scl & pin_prev_reg.scl;
    wire logic start_c  = pin_reg.scl & pin_prev_reg.scl
                          & pin_prev_reg.sda & ~pin_reg.sda;
    wire logic stop_c   = pin_reg.scl & pin_prev_reg.scl
                          & ~pin_prev_reg.sda & pin_reg.sda;

    // ------------------------------------------------------------
    // Word store, system domain
    // ------------------------------------------------------------
    logic [15:0] mem_reg [0:15];
    logic        cfg_loaded_reg;
    logic        wr_tog_l_reg;
    sts_pkg::sts_wr_s wr_l_reg;
    logic [2:0]  wr_sync_reg;
    // Shadows of address and config crossing to the link side
    logic [6:0]  own_addr_reg;
    // R5: fixed word map; R6: identifier words read-only
    // R21: emissivity resets to unity, compensation off
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mem_reg[sts_pkg::OFF_FLOOR_ADDR] <= sts_pkg::RST_FLOOR_ADDR;
            mem_reg[sts_pkg::OFF_SPAN]       <= sts_pkg::RST_SPAN;
            mem_reg[sts_pkg::OFF_CONFIG]     <= sts_pkg::RST_CONFIG;
            mem_reg[sts_pkg::OFF_EMISS]      <= sts_pkg::RST_EMISS;
            for (int i = int'(sts_pkg::OFF_CAL_FIRST);
                 i <= int'(sts_pkg::OFF_CAL_LAST); i++)
                mem_reg[i] <= sts_pkg::RST_CAL;
            mem_reg[sts_pkg::OFF_ID_LOW]     <= ID_LOW;
            mem_reg[sts_pkg::OFF_ID_HIGH]    <= ID_HIGH;
        end else if ((wr_sync_reg[2] ^ wr_sync_reg[1])
                     && (wr_l_reg.addr < sts_pkg::OFF_ID_LOW)) begin
            // R7: calibration stays writable; master must leave it
            mem_reg[wr_l_reg.addr] <= wr_l_reg.data;
        end
    end
    // Toggle crossing for write events; data held stable meanwhile
    always_ff @(posedge clk_sys) begin
        if (!rst_n) wr_sync_reg <= '0;
        else wr_sync_reg <= {wr_sync_reg[1:0], wr_tog_l_reg};
    end
    // R10: config applied one cycle after reset release
    always_ff @(posedge clk_sys) begin
        if (!rst_n) cfg_loaded_reg <= 1'b0;
        else cfg_loaded_reg <= 1'b1;
    end
    // R2: own address from bits 6..0 of word 0
    always_ff @(posedge clk_sys) begin
        if (!rst_n) own_addr_reg <= sts_pkg::RST_FLOOR_ADDR[6:0];
        else own_addr_reg <= mem_reg[sts_pkg::OFF_FLOOR_ADDR]
                             [sts_pkg::ADDR_MSB:0];
    end
    // R8 R9: PWM limits from right-justified 15-bit fields
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pwm_floor <= '0;
            pwm_span  <= '0;
            pwm_sel_ambient <= 1'b0;
        end else begin
            pwm_floor <= mem_reg[sts_pkg::OFF_FLOOR_ADDR]
                         [sts_pkg::TEMP_MSB:0];
            pwm_span  <= mem_reg[sts_pkg::OFF_SPAN][sts_pkg::TEMP_MSB:0];
            pwm_sel_ambient <= mem_reg[sts_pkg::OFF_CONFIG][2];
        end
    end
    // R11: weak reset indication only while reset holds
    assign por_weak_oe = ~rst_n;

    // ------------------------------------------------------------
    // Mode control: PWM or serial, wake from power saving
    // ------------------------------------------------------------
    logic [2:0]  scl_sys_reg;
    logic [31:0] low_cnt_reg;
    logic        serial_mode_reg;
    logic        awake_reg;
    // Three-stage sample of the clock pin in the system domain
    always_ff @(posedge clk_sys) begin
        if (!rst_n) scl_sys_reg <= '1;
        else scl_sys_reg <= {scl_sys_reg[1:0], scl_in};
    end
    // R17: lengths counted in oscillator cycles
    always_ff @(posedge clk_sys) begin
        if (!rst_n) low_cnt_reg <= '0;
        else if (scl_sys_reg[2] | scl_sys_reg[1]) low_cnt_reg <= '0;
        else if (low_cnt_reg != 32'hffffffff)
            low_cnt_reg <= low_cnt_reg + 32'h1;
    end
    // R19 R18: bit 0 picks mode; long low forces serial
    // A rewritten config word takes effect at once, sparing a power cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) serial_mode_reg <= 1'b1;
        else if (!cfg_loaded_reg)
            serial_mode_reg <= mem_reg[sts_pkg::OFF_CONFIG]
                               [sts_pkg::CFG_SEL_BIT];
        else if ((wr_sync_reg[2] ^ wr_sync_reg[1])
                 && wr_l_reg.addr == sts_pkg::OFF_CONFIG)
            serial_mode_reg <= wr_l_reg.data[sts_pkg::CFG_SEL_BIT];
        else if (low_cnt_reg >= 32'(REQ_CYC)) serial_mode_reg <= 1'b1;
    end
    // R23: clock low of wake length ends power saving
    always_ff @(posedge clk_sys) begin
        if (!rst_n) awake_reg <= 1'b1;
        else if (!awake_reg && low_cnt_reg >= 32'(WAKE_CYC))
            awake_reg <= 1'b1;
        else if (sleep_req) awake_reg <= 1'b0;
    end
    assign awake = awake_reg;
    // R13 R12: only one result path active; PWM picks source
    assign pwm_active = ~serial_mode_reg & awake_reg;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) pwm_value <= '0;
        else pwm_value <= pwm_sel_ambient ? ambient_temp : object_temp;
    end
    // R14 R15 R16: results arrive filtered at 0.02 steps from DSP

    // ------------------------------------------------------------
    // Serial engine, link domain
    // ------------------------------------------------------------
    sts_pkg::sts_state_e st_reg;
    logic [7:0]  sh_reg;
    logic [3:0]  bit_reg;
    logic [1:0]  byte_reg;
    logic        rnw_reg;
    logic [7:0]  cmd_reg;
    logic [7:0]  lo_reg;
    logic [23:0] tx_reg;
    logic [7:0]  crc_reg;
    logic        drive_reg;
    logic [31:0] to_cnt_reg;
    logic [6:0]  addr_l1_reg, addr_l2_reg;
    logic        ser_l1_reg, ser_l2_reg;
    // Address and mode word cross as quasi-static levels
    always_ff @(posedge clk_link) begin
        if (!rst_n) begin
            addr_l1_reg <= sts_pkg::RST_FLOOR_ADDR[6:0];
            addr_l2_reg <= sts_pkg::RST_FLOOR_ADDR[6:0];
            ser_l1_reg  <= 1'b1;
            ser_l2_reg  <= 1'b1;
        end else begin
            addr_l1_reg <= own_addr_reg;
            addr_l2_reg <= addr_l1_reg;
            ser_l1_reg  <= serial_mode_reg;
            ser_l2_reg  <= ser_l1_reg;
        end
    end
    // R22: clock level held too long abandons transfer
    always_ff @(posedge clk_link) begin
        if (!rst_n || scl_rise || scl_fall || st_reg == sts_pkg::ST_IDLE)
            to_cnt_reg <= '0;
        else if (to_cnt_reg != 32'hffffffff)
            to_cnt_reg <= to_cnt_reg + 32'h1;
    end
    wire logic timeout = pin_reg.scl ? (to_cnt_reg >= 32'(HIGH_TO_CYC))
                                     : (to_cnt_reg >= 32'(LOW_TO_CYC));
    // CRC-8 update of one byte
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? ((r << 1) ^ sts_pkg::CRC_POLY) : (r << 1);
        return r;
    endfunction
    wire logic [7:0] rx_byte = {sh_reg[6:0], pin_reg.sda};
    // R1: responds only; no start is ever produced here
    always_ff @(posedge clk_link) begin
        if (!rst_n || stop_c || timeout || !ser_l2_reg) begin
            st_reg <= sts_pkg::ST_IDLE;
            drive_reg <= 1'b0;
        end else if (start_c) begin
            st_reg <= sts_pkg::ST_ADDR;
            bit_reg <= '0;
            byte_reg <= '0;
            drive_reg <= 1'b0;
            crc_reg <= '0;
        end else begin
            case (st_reg)
                sts_pkg::ST_ADDR, sts_pkg::ST_WRB: begin
                    if (scl_rise) begin
                        sh_reg <= rx_byte;
                        bit_reg <= bit_reg + 4'h1;
                    end
                    if (scl_fall && bit_reg == 4'h8) begin
                        bit_reg <= '0;
                        crc_reg <= crc8(crc_reg, sh_reg);
                        if (st_reg == sts_pkg::ST_ADDR) begin
                            rnw_reg <= sh_reg[0];
                            // R2 R3 R4: own address or zero selects
                            if (sh_reg[7:1] == addr_l2_reg
                                || sh_reg[7:1] == sts_pkg::GEN_CALL) begin
                                drive_reg <= 1'b1;
                                st_reg <= sts_pkg::ST_AACK;
                            end else st_reg <= sts_pkg::ST_IDLE;
                        end else begin
                            drive_reg <= 1'b1;
                            st_reg <= sts_pkg::ST_WACK;
                            byte_reg <= byte_reg + 2'h1;
                            if (byte_reg == 2'h0) cmd_reg <= sh_reg;
                            if (byte_reg == 2'h1) lo_reg <= sh_reg;
                            if (byte_reg == 2'h2) begin
                                wr_l_reg <= '{addr: cmd_reg[3:0],
                                              data: {sh_reg, lo_reg}};
                            end
                        end
                    end
                end
                sts_pkg::ST_AACK, sts_pkg::ST_WACK: begin
                    if (scl_fall) begin
                        drive_reg <= 1'b0;
                        if (rnw_reg && st_reg == sts_pkg::ST_AACK) begin
                            // R20: word low byte, high byte, then PEC
                            tx_reg <= {mem_reg[cmd_reg[3:0]][7:0],
                                       mem_reg[cmd_reg[3:0]][15:8],
                                       crc8(crc8(crc_reg,
                                         mem_reg[cmd_reg[3:0]][7:0]),
                                         mem_reg[cmd_reg[3:0]][15:8])};
                            st_reg <= sts_pkg::ST_RDB;
                            drive_reg <= ~mem_reg[cmd_reg[3:0]][7];
                        end else st_reg <= sts_pkg::ST_WRB;
                    end
                end
                sts_pkg::ST_RDB: begin
                    if (scl_fall) begin
                        bit_reg <= bit_reg + 4'h1;
                        tx_reg <= {tx_reg[22:0], 1'b1};
                        if (bit_reg == 4'h7) begin
                            drive_reg <= 1'b0;
                            st_reg <= sts_pkg::ST_RACK;
                        end else drive_reg <= ~tx_reg[22];
                    end
                end
                sts_pkg::ST_RACK: begin
                    if (scl_rise && pin_reg.sda) st_reg <= sts_pkg::ST_IDLE;
                    else if (scl_fall) begin
                        bit_reg <= '0;
                        st_reg <= sts_pkg::ST_RDB;
                        drive_reg <= ~tx_reg[23];
                    end
                end
                default: st_reg <= sts_pkg::ST_IDLE;
            endcase
        end
    end
    // Write toggle flips when the high data byte's ack ends
    // Kept apart from the engine so stop or timeout never rewinds it
    wire logic wr_done = scl_fall && !timeout && ser_l2_reg
                         && st_reg == sts_pkg::ST_WACK && byte_reg == 2'h3;
    always_ff @(posedge clk_link) begin
        if (!rst_n) wr_tog_l_reg <= 1'b0;
        else if (wr_done) wr_tog_l_reg <= ~wr_tog_l_reg;
    end
    assign sda_oe = drive_reg & ser_l2_reg;
endmodule
`default_nettype wire
